// ==== rtl/loader_pkg.sv ====
// Shared constants and types for the serial-configuration word loader.
// Assumes a word-fetch engine on the same clock that reads the EEPROM.
package loader_pkg;

	// ------------------------------------------------------------
	// Sizes
	// ------------------------------------------------------------
	localparam int WORD_W = 16;
	localparam int N_SLOTS = 7;
	localparam int N_PORTS = 4;
	localparam int SLOT_W = 3;
	localparam int REG_AW = 8;
	localparam int EE_AW = 8;

	// ------------------------------------------------------------
	// EEPROM word addresses, in fetch order
	// ------------------------------------------------------------
	localparam logic [EE_AW-1:0] EE_PM3 = 8'h56;
	localparam logic [EE_AW-1:0] EE_LINK0 = 8'h58;
	localparam logic [EE_AW-1:0] EE_LINK1 = 8'h5a;
	localparam logic [EE_AW-1:0] EE_LINK2 = 8'h5c;
	localparam logic [EE_AW-1:0] EE_LINK3 = 8'h5e;
	localparam logic [EE_AW-1:0] EE_MISC0 = 8'h60;
	localparam logic [EE_AW-1:0] EE_MISC1 = 8'h62;
	localparam logic [SLOT_W-1:0] SLOT_PM3 = 3'h0;
	localparam logic [SLOT_W-1:0] SLOT_LINK0 = 3'h1;
	localparam logic [SLOT_W-1:0] SLOT_MISC0 = 3'h5;
	localparam logic [SLOT_W-1:0] SLOT_MISC1 = 3'h6;
	localparam logic [SLOT_W-1:0] SLOT_LAST = 3'h6;

	// ------------------------------------------------------------
	// Word values after reset (unprogrammed part)
	// ------------------------------------------------------------
	localparam logic [WORD_W-1:0] DEF_PM3 = 16'h00ff;
	localparam logic [WORD_W-1:0] DEF_LINK = 16'h0000;
	localparam logic [WORD_W-1:0] DEF_MISC0 = 16'hfe02;
	localparam logic [WORD_W-1:0] DEF_MISC1 = 16'hfe12;

	// ------------------------------------------------------------
	// Source bit in the word, destination bit in the dword
	// ------------------------------------------------------------
	localparam int SRC_NSR = 0;
	localparam int DST_NSR = 3;
	localparam int SRC_AUX = 1;
	localparam int DST_AUX = 22;
	localparam int SRC_D1 = 4;
	localparam int DST_D1 = 25;
	localparam int SRC_D2 = 5;
	localparam int DST_D2 = 26;
	localparam int SRC_PME = 6;
	localparam int DST_PME = 28;
	localparam int SRC_PMD = 8;
	localparam int DST_PMD = 24;
	localparam int SRC_SLOT_IMPL = 0;
	localparam int DST_SLOT_IMPL = 24;
	localparam int SRC_SLOT_CLK = 1;
	localparam int DST_SLOT_CLK = 28;
	localparam int SRC_DSI = 2;
	localparam int DST_DSI = 21;
	localparam int SRC_LPVC = 3;
	localparam int DST_LPVC = 4;
	localparam int SRC_PNUM = 4;
	localparam int DST_PNUM = 24;
	localparam int SRC_TCMAP = 9;
	localparam int DST_TCMAP = 1;

	// ------------------------------------------------------------
	// Software register map (byte offsets)
	// ------------------------------------------------------------
	localparam logic [REG_AW-1:0] OFS_STATUS = 8'h00;
	localparam logic [REG_AW-1:0] OFS_CTRL = 8'h04;
	localparam logic [REG_AW-1:0] OFS_WORD0 = 8'h10;
	localparam int CTRL_RELOAD = 0;
	localparam int CTRL_ERR_CLR = 1;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_FETCH = 3'b010,
		ST_DONE = 3'b100
	} load_state_e;

	// Field images of one port, unmapped bits zero
	typedef struct packed {
		logic [31:0] dw340;
		logic [31:0] dw154;
		logic [31:0] dw144;
		logic [31:0] dwd0;
		logic [31:0] dwcc;
		logic [31:0] dwc0;
		logic [31:0] dw44;
		logic [31:0] dw40;
	} cfg_img_s;

	typedef struct packed {
		logic en;
		logic oor;
		logic [REG_AW-1:0] addr;
		logic [31:0] data;
		logic [3:0] strb;
	} reg_wr_s;

	typedef struct packed {
		logic oor;
		logic [REG_AW-1:0] addr;
	} reg_rd_s;

	typedef struct packed {
		logic ok;
		logic [31:0] data;
	} reg_rd_ans_s;

endpackage

// ==== rtl/axil_reg_port.sv ====
// AXI4-Lite slave front end: one write and one read in flight.
// Assumes the register owner answers reads and write checks combinationally.
`timescale 1ns/1ps
module axil_reg_port
	import loader_pkg::*;
#(
	parameter int ADDR_W = 12
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Write address and data
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// Write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// Read address and data
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Register side
	output reg_wr_s wr_req,
	input wire logic wr_ok,
	output reg_rd_s rd_req,
	input wire reg_rd_ans_s rd_ans
);

	if (ADDR_W <= REG_AW)
	begin : g_chk
		$error("ADDR_W must exceed the register offset width");
	end

	logic [ADDR_W-1:0] awaddr_ff, nxt_awaddr;
	logic aw_held_ff, nxt_aw_held;
	logic [31:0] wdata_ff, nxt_wdata;
	logic [3:0] wstrb_ff, nxt_wstrb;
	logic w_held_ff, nxt_w_held;
	logic bvalid_ff, nxt_bvalid;
	logic [1:0] bresp_ff, nxt_bresp;
	logic rvalid_ff, nxt_rvalid;
	logic [31:0] rdata_ff, nxt_rdata;
	logic [1:0] rresp_ff, nxt_rresp;
	logic fire;

	// Channel handshakes; address and data may arrive in either order
	always_comb
	begin
		s_axi_awready = !aw_held_ff && !bvalid_ff;
		s_axi_wready = !w_held_ff && !bvalid_ff;
		s_axi_arready = !rvalid_ff;
		fire = aw_held_ff && w_held_ff && !bvalid_ff;
		wr_req.en = fire;
		wr_req.oor = |awaddr_ff[ADDR_W-1:REG_AW];
		wr_req.addr = awaddr_ff[REG_AW-1:0];
		wr_req.data = wdata_ff;
		wr_req.strb = wstrb_ff;
		rd_req.oor = |s_axi_araddr[ADDR_W-1:REG_AW];
		rd_req.addr = s_axi_araddr[REG_AW-1:0];
		nxt_awaddr = (s_axi_awvalid && s_axi_awready) ? s_axi_awaddr : awaddr_ff;
		nxt_aw_held = fire ? 1'b0 : (aw_held_ff || (s_axi_awvalid && s_axi_awready));
		nxt_wdata = (s_axi_wvalid && s_axi_wready) ? s_axi_wdata : wdata_ff;
		nxt_wstrb = (s_axi_wvalid && s_axi_wready) ? s_axi_wstrb : wstrb_ff;
		nxt_w_held = fire ? 1'b0 : (w_held_ff || (s_axi_wvalid && s_axi_wready));
		nxt_bvalid = fire ? 1'b1 : (bvalid_ff && !s_axi_bready);
		nxt_bresp = fire ? (wr_ok ? RESP_OKAY : RESP_SLVERR) : bresp_ff;
		nxt_rvalid = (s_axi_arvalid && s_axi_arready) ? 1'b1 : (rvalid_ff && !s_axi_rready);
		nxt_rdata = rdata_ff;
		nxt_rresp = rresp_ff;
		if (s_axi_arvalid && s_axi_arready)
		begin
			nxt_rdata = rd_ans.ok ? rd_ans.data : 32'h0000_0000;
			nxt_rresp = rd_ans.ok ? RESP_OKAY : RESP_SLVERR;
		end
	end

	// Channel state
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			awaddr_ff <= '0;
			aw_held_ff <= 1'b0;
			wdata_ff <= 32'h0000_0000;
			wstrb_ff <= 4'h0;
			w_held_ff <= 1'b0;
			bvalid_ff <= 1'b0;
			bresp_ff <= RESP_OKAY;
			rvalid_ff <= 1'b0;
			rdata_ff <= 32'h0000_0000;
			rresp_ff <= RESP_OKAY;
		end
		else
		begin
			awaddr_ff <= nxt_awaddr;
			aw_held_ff <= nxt_aw_held;
			wdata_ff <= nxt_wdata;
			wstrb_ff <= nxt_wstrb;
			w_held_ff <= nxt_w_held;
			bvalid_ff <= nxt_bvalid;
			bresp_ff <= nxt_bresp;
			rvalid_ff <= nxt_rvalid;
			rdata_ff <= nxt_rdata;
			rresp_ff <= nxt_rresp;
		end
	end

	assign s_axi_bvalid = bvalid_ff;
	assign s_axi_bresp = bresp_ff;
	assign s_axi_rvalid = rvalid_ff;
	assign s_axi_rdata = rdata_ff;
	assign s_axi_rresp = rresp_ff;

endmodule

// ==== rtl/eeprom_config_word_loader.sv ====
// Loads configuration words 56h..62h from the serial EEPROM into per-port
// configuration field images of a four-port switch.
// Assumes a word-fetch engine on clk that answers each request with ee_ack.
`timescale 1ns/1ps
module eeprom_config_word_loader
	import loader_pkg::*;
#(
	parameter int ADDR_W = 12
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// AXI4-Lite write channels
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read channels
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// EEPROM word fetch
	output logic ee_req,
	output logic [EE_AW-1:0] ee_addr,
	input wire logic ee_ack,
	input wire logic ee_err,
	input wire logic [WORD_W-1:0] ee_data,
	// Port configuration side
	output logic cfg_ready,
	output cfg_img_s [N_PORTS-1:0] cfg_img
);

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------

	// EEPROM word address of a fetch slot
	function automatic logic [EE_AW-1:0] slot_addr(input logic [SLOT_W-1:0] s);
		logic [EE_AW-1:0] a;
		case (s)
			3'h0: a = EE_PM3;
			3'h1: a = EE_LINK0;
			3'h2: a = EE_LINK1;
			3'h3: a = EE_LINK2;
			3'h4: a = EE_LINK3;
			3'h5: a = EE_MISC0;
			default: a = EE_MISC1;
		endcase
		return a;
	endfunction

	// Value a slot holds before (or without) a successful fetch
	function automatic logic [WORD_W-1:0] slot_default(input logic [SLOT_W-1:0] s);
		logic [WORD_W-1:0] d;
		case (s)
			SLOT_PM3: d = DEF_PM3;
			SLOT_MISC0: d = DEF_MISC0;
			SLOT_MISC1: d = DEF_MISC1;
			default: d = DEF_LINK;
		endcase
		return d;
	endfunction

	// Scatter the relevant words into one port's field images
	function automatic cfg_img_s build_img(
		input int p,
		input logic [WORD_W-1:0] link,
		input logic [WORD_W-1:0] pm,
		input logic [WORD_W-1:0] misc
	);
		cfg_img_s img;
		img = '0;
		img.dw340[WORD_W-1:0] = link;
		if (p == N_PORTS - 1)
		begin
			img.dw44[DST_NSR] = pm[SRC_NSR];
			img.dw40[DST_AUX +: 3] = pm[SRC_AUX +: 3];
			img.dw40[DST_D1] = pm[SRC_D1];
			img.dw40[DST_D2] = pm[SRC_D2];
			img.dw40[DST_PME +: 2] = pm[SRC_PME +: 2];
			img.dw44[DST_PMD +: 8] = pm[SRC_PMD +: 8];
		end
		if (p < 2)
		begin
			img.dwd0[DST_SLOT_CLK] = misc[SRC_SLOT_CLK];
			img.dw40[DST_DSI] = misc[SRC_DSI];
			img.dw144[DST_LPVC] = misc[SRC_LPVC];
			img.dwcc[DST_PNUM +: 3] = misc[SRC_PNUM +: 3];
			img.dw154[DST_TCMAP +: 7] = misc[SRC_TCMAP +: 7];
		end
		if (p == 1)
		begin
			img.dwc0[DST_SLOT_IMPL] = misc[SRC_SLOT_IMPL];
		end
		return img;
	endfunction

	// ------------------------------------------------------------
	// Register bus front end
	// ------------------------------------------------------------
	reg_wr_s wr_req;
	reg_rd_s rd_req;
	reg_rd_ans_s rd_ans;
	logic wr_ok;

	axil_reg_port #(
		.ADDR_W(ADDR_W)
	) u_port (
		.clk(clk),
		.rst(rst),
		.s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready),
		.wr_req(wr_req),
		.wr_ok(wr_ok),
		.rd_req(rd_req),
		.rd_ans(rd_ans)
	);

	// ------------------------------------------------------------
	// Control decode
	// ------------------------------------------------------------
	logic reload;
	logic err_clr;

	// Only the control word is writable; other writes answer SLVERR
	always_comb
	begin
		wr_ok = !wr_req.oor && (wr_req.addr == OFS_CTRL);
		reload = wr_req.en && wr_ok && wr_req.strb[0] && wr_req.data[CTRL_RELOAD];
		err_clr = wr_req.en && wr_ok && wr_req.strb[0] && wr_req.data[CTRL_ERR_CLR];
	end

	// ------------------------------------------------------------
	// Fetch sequencer
	// ------------------------------------------------------------
	load_state_e state_ff, nxt_state;
	logic [SLOT_W-1:0] slot_ff, nxt_slot;
	logic [EE_AW-1:0] addr_ff, nxt_addr;
	logic [WORD_W-1:0] words_ff [N_SLOTS];
	logic [WORD_W-1:0] nxt_words [N_SLOTS];
	logic err_ff, nxt_err;

	// One pass over the word list; a failed read keeps that slot's default.
	// A reload restores defaults first so a vanished part cannot leave
	// stale words behind.
	always_comb
	begin
		nxt_state = state_ff;
		nxt_slot = slot_ff;
		nxt_addr = addr_ff;
		nxt_words = words_ff;
		// Error flag: a new error wins over a clear in the same cycle
		nxt_err = err_clr ? 1'b0 : err_ff;
		case (state_ff)
			ST_IDLE:
			begin
				nxt_state = ST_FETCH;
				nxt_slot = '0;
				nxt_addr = slot_addr('0);
			end
			ST_FETCH:
			begin
				if (ee_ack)
				begin
					if (ee_err)
						nxt_err = 1'b1;
					else
						nxt_words[slot_ff] = ee_data;
					if (slot_ff == SLOT_LAST)
						nxt_state = ST_DONE;
					else
					begin
						nxt_slot = slot_ff + 3'h1;
						nxt_addr = slot_addr(slot_ff + 3'h1);
					end
				end
			end
			ST_DONE:
			begin
				nxt_state = ST_DONE;
			end
			default:
			begin
				nxt_state = ST_IDLE;
			end
		endcase
		if (reload)
		begin
			nxt_state = ST_IDLE;
			for (int i = 0; i < N_SLOTS; i++)
				nxt_words[i] = slot_default(SLOT_W'(i));
		end
	end

	// Sequencer state
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			state_ff <= ST_IDLE;
			slot_ff <= '0;
			addr_ff <= EE_PM3;
			err_ff <= 1'b0;
			words_ff[0] <= DEF_PM3;
			words_ff[1] <= DEF_LINK;
			words_ff[2] <= DEF_LINK;
			words_ff[3] <= DEF_LINK;
			words_ff[4] <= DEF_LINK;
			words_ff[5] <= DEF_MISC0;
			words_ff[6] <= DEF_MISC1;
		end
		else
		begin
			state_ff <= nxt_state;
			slot_ff <= nxt_slot;
			addr_ff <= nxt_addr;
			err_ff <= nxt_err;
			words_ff <= nxt_words;
		end
	end

	// Request stands for the whole fetch state until acknowledged
	assign ee_req = (state_ff == ST_FETCH);
	assign ee_addr = addr_ff;

	// ------------------------------------------------------------
	// Field images and configuration gate
	// ------------------------------------------------------------
	cfg_img_s [N_PORTS-1:0] img_ff, nxt_img;
	logic ready_ff, nxt_ready;

	// Images follow the words one cycle later; ready lags done by the
	// same cycle so ports never open on a half-built image
	always_comb
	begin
		for (int p = 0; p < N_PORTS; p++)
		begin
			// port 1 takes the 62h misc word, port 0 60h; ports 2 and 3 use no misc bits
			nxt_img[p] = build_img(p, words_ff[int'(SLOT_LINK0) + p], words_ff[SLOT_PM3],
				(p == 1) ? words_ff[SLOT_MISC1] : words_ff[SLOT_MISC0]);
		end
		nxt_ready = (state_ff == ST_DONE) && !reload;
	end

	// Image registers
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			img_ff <= '0;
			ready_ff <= 1'b0;
		end
		else
		begin
			img_ff <= nxt_img;
			ready_ff <= nxt_ready;
		end
	end

	assign cfg_img = img_ff;
	assign cfg_ready = ready_ff;

	// ------------------------------------------------------------
	// Register read map
	// ------------------------------------------------------------
	logic [REG_AW-1:0] word_ofs;

	// Status, control (reads zero) and the seven raw words
	always_comb
	begin
		rd_ans.ok = 1'b0;
		rd_ans.data = 32'h0000_0000;
		word_ofs = rd_req.addr - OFS_WORD0;
		if (!rd_req.oor)
		begin
			if (rd_req.addr == OFS_STATUS)
			begin
				rd_ans.ok = 1'b1;
				rd_ans.data = {25'h0, slot_ff, 1'b0, err_ff, ee_req, ready_ff};
			end
			else if (rd_req.addr == OFS_CTRL)
				rd_ans.ok = 1'b1;
			else if (rd_req.addr >= OFS_WORD0 && word_ofs[1:0] == 2'h0
				&& word_ofs[REG_AW-1:2] < 6'(N_SLOTS))
			begin
				rd_ans.ok = 1'b1;
				rd_ans.data = {16'h0000, words_ff[word_ofs[4:2]]};
			end
		end
	end

endmodule

// ==== verification/loader_sva.sv ====
// Checker for the config word loader: fetch order and field images.
// Sees only top-level ports; bound to the loader at the foot of this file.
`timescale 1ns/1ps
module loader_sva
	import loader_pkg::*;
(
	// Clock and reset
	input logic clk,
	input logic rst,
	// Word fetch
	input logic ee_req,
	input logic [EE_AW-1:0] ee_addr,
	input logic ee_ack,
	input logic ee_err,
	input logic [WORD_W-1:0] ee_data,
	// Images
	input logic cfg_ready,
	input cfg_img_s [N_PORTS-1:0] cfg_img
);
	localparam logic [WORD_W-1:0] DEFS [N_SLOTS] = '{DEF_PM3, DEF_LINK, DEF_LINK, DEF_LINK,
		DEF_LINK, DEF_MISC0, DEF_MISC1};
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	logic [WORD_W-1:0] w_ff [N_SLOTS];
	logic [WORD_W-1:0] nxt_w [N_SLOTS];
	logic [EE_AW-1:0] slot_idx;
	// Shadow of each answered word; a failed read leaves the default
	assign slot_idx = (ee_addr - EE_PM3) >> 1;
	always_comb
	begin
		nxt_w = w_ff;
		if (ee_req && ee_ack && slot_idx < 8'(N_SLOTS))
			nxt_w[slot_idx] = ee_err ? DEFS[slot_idx] : ee_data;
	end
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			w_ff <= DEFS;
		else
			w_ff <= nxt_w;
	end
	property p_first_word;
		$rose(ee_req) |-> ee_addr == EE_PM3 && !cfg_ready;
	endproperty
	a_first_word: assert property (p_first_word) else $error("fetch did not start at 56h");
	property p_addr_hold;
		ee_req && !ee_ack |=> ee_req && $stable(ee_addr);
	endproperty
	a_addr_hold: assert property (p_addr_hold) else $error("fetch request moved");
	property p_next_word;
		ee_req && ee_ack && ee_addr != EE_MISC1 |=> ee_req && ee_addr == $past(ee_addr) + 8'h02;
	endproperty
	a_next_word: assert property (p_next_word) else $error("word order broken");
	property p_last_word;
		ee_req && ee_ack && ee_addr == EE_MISC1 |=> !ee_req ##1 cfg_ready;
	endproperty
	a_last_word: assert property (p_last_word) else $error("no ready after last word");
	property p_ready_quiet;
		cfg_ready |-> !ee_req;
	endproperty
	a_ready_quiet: assert property (p_ready_quiet) else $error("fetch while ready");
	property p_pm3;
		cfg_ready |-> cfg_img[3].dw44 == {w_ff[0][15:8], 20'h0, w_ff[0][0], 3'h0};
	endproperty
	a_pm3: assert property (p_pm3) else $error("port 3 dword 44h wrong");
	property p_pmcap;
		cfg_ready |-> cfg_img[3].dw40 == {2'h0, w_ff[0][7:6], 1'h0, w_ff[0][5:1], 22'h0};
	endproperty
	a_pmcap: assert property (p_pmcap) else $error("port 3 dword 40h wrong");
	property p_link;
		cfg_ready |-> cfg_img[0].dw340 == {16'h0, w_ff[1]} && cfg_img[1].dw340 == {16'h0, w_ff[2]}
			&& cfg_img[2].dw340 == {16'h0, w_ff[3]} && cfg_img[3].dw340 == {16'h0, w_ff[4]};
	endproperty
	a_link: assert property (p_link) else $error("link control word wrong");
	property p_misc;
		cfg_ready |-> cfg_img[0].dwd0[28] == w_ff[5][1] && cfg_img[1].dw40[21] == w_ff[6][2]
			&& cfg_img[0].dw144[4] == w_ff[5][3] && cfg_img[1].dwcc[26:24] == w_ff[6][6:4]
			&& cfg_img[0].dw154[7:1] == w_ff[5][15:9] && cfg_img[1].dwc0[24] == w_ff[6][0];
	endproperty
	a_misc: assert property (p_misc) else $error("slot fields wrong");
	// Port 2 takes only its link word here; stray bits mean a miswired field
	property p_unmapped;
		cfg_ready |-> (cfg_img[2] & ~{32'hffff, 224'h0}) == '0
			&& (cfg_img[3].dw40 & ~32'h37c00000) == 32'h0;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped bit set");
endmodule
bind eeprom_config_word_loader loader_sva chk (.clk, .rst, .ee_req, .ee_addr, .ee_ack,
	.ee_err, .ee_data, .cfg_ready, .cfg_img);

// ==== verification/ee_word_model.sv ====
// Behavioural serial EEPROM seen as a word server for the loader.
// Answers one word per request after lat idle cycles; the bench fills mem.
`timescale 1ns/1ps
module ee_word_model
	import loader_pkg::*;
(
	// Clock and reset
	input logic clk,
	input logic rst,
	// Word fetch
	input logic ee_req,
	input logic [EE_AW-1:0] ee_addr,
	output logic ee_ack,
	output logic ee_err,
	output logic [WORD_W-1:0] ee_data,
	// Behaviour knobs
	input logic [3:0] lat,
	input logic [EE_AW-1:0] bad_addr
);
	logic [WORD_W-1:0] mem [256];
	logic [3:0] cnt_ff;
	// Data toggles outside an answer so a stale word never looks fresh
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			ee_ack <= 1'b0;
			ee_err <= 1'b0;
			ee_data <= 16'h5a5a;
			cnt_ff <= 4'h0;
		end
		else
		begin
			ee_ack <= 1'b0;
			ee_err <= 1'b0;
			ee_data <= ~ee_data;
			if (ee_req && !ee_ack)
			begin
				cnt_ff <= cnt_ff + 4'h1;
				if (cnt_ff >= lat)
				begin
					ee_ack <= 1'b1;
					ee_err <= ee_addr == bad_addr;
					ee_data <= mem[ee_addr];
					cnt_ff <= 4'h0;
				end
			end
		end
	end
endmodule

// ==== verification/testbench.sv ====
// Self-checking bench for the config word loader.
// Drives the register bus, serves words from the EEPROM model.
`timescale 1ns/1ps
module testbench
	import loader_pkg::*;
;
	logic clk, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic ee_req, ee_ack, ee_err, cfg_ready;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb, lat;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [7:0] ee_addr, bad_addr;
	logic [15:0] ee_data;
	logic [15:0] wv [7];
	cfg_img_s [N_PORTS-1:0] cfg_img;
	int mismatches, checks, cycles, i, p, it;
	eeprom_config_word_loader #(.ADDR_W(12)) uut (.clk, .rst, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ee_req, .ee_addr, .ee_ack, .ee_err, .ee_data,
		.cfg_ready, .cfg_img);
	ee_word_model pm (.clk, .rst, .ee_req, .ee_addr, .ee_ack, .ee_err, .ee_data, .lat, .bad_addr);
	always #25 clk = ~clk;
	// Watchdog: a hang counts as a mismatch
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			mismatches++;
			print_verdict();
		end
	end
	task automatic print_verdict();
		if (mismatches == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [255:0] e, input logic [255:0] s);
		checks++;
		if (s !== e)
		begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", nm, e, s);
		end
	endtask
	function automatic logic [15:0] defw(input int k);
		return k == 0 ? DEF_PM3 : k < 5 ? DEF_LINK : k == 5 ? DEF_MISC0 : DEF_MISC1;
	endfunction
	// Expected image of one port from the words the model served
	function automatic cfg_img_s exp_img(input int q);
		cfg_img_s e;
		logic [15:0] m;
		e = '0;
		e.dw340[15:0] = wv[1 + q];
		if (q == 3)
		begin
			e.dw44 = {wv[0][15:8], 20'h0, wv[0][0], 3'h0};
			e.dw40 = {2'h0, wv[0][7:6], 1'h0, wv[0][5:1], 22'h0};
		end
		if (q < 2)
		begin
			m = wv[5 + q];
			e.dwd0[28] = m[1];
			e.dw40[21] = m[2];
			e.dw144[4] = m[3];
			e.dwcc[26:24] = m[6:4];
			e.dw154[7:1] = m[15:9];
			if (q == 1)
				e.dwc0[24] = m[0];
		end
		return e;
	endfunction
	// Bus master tasks: hold each channel until its own ready
	task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do
		begin
			@(posedge clk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
		chk("bresp", er, s_axi_bresp);
	endtask
	task automatic axi_rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m,
		input logic [1:0] er);
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do
		begin
			@(posedge clk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
		chk("rdata", e & m, s_axi_rdata & m);
		chk("rresp", er, s_axi_rresp);
	endtask
	// Loads with random, all-ones, failed-word and slow-partner corners
	initial
	begin
		{clk, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, lat, bad_addr} = '0;
		s_axi_wstrb = 4'hf;
		rst = 1'b1;
		void'($urandom(32'h20f39d29));
		for (i = 0; i < 256; i++)
			pm.mem[i] = 16'($urandom);
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		for (it = 0; it < 4; it++)
		begin
			if (it > 0)
			begin
				lat <= it == 1 ? 4'h0 : it == 3 ? 4'hf : 4'($urandom_range(1, 14));
				bad_addr <= it == 2 ? EE_PM3 + 8'($urandom_range(0, 6) * 2) : 8'h00;
				for (i = 0; i < 7; i++)
					pm.mem[EE_PM3 + 2 * i] = it == 1 ? 16'hffff : 16'($urandom);
				axi_wr({4'h0, OFS_CTRL}, 32'h1, RESP_OKAY);
				chk("ready_drop", 1'b0, cfg_ready);
			end
			while (cfg_ready !== 1'b1)
				@(posedge clk);
			for (i = 0; i < 7; i++)
				wv[i] = EE_PM3 + 8'(2 * i) == bad_addr ? defw(i) : pm.mem[EE_PM3 + 2 * i];
			for (p = 0; p < 4; p++)
				chk("cfg_img", exp_img(p), cfg_img[p]);
			for (i = 0; i < 7; i++)
				axi_rd({4'h0, OFS_WORD0} + 12'(4 * i), {16'h0, wv[i]}, '1, RESP_OKAY);
			// Status in full: the sequencer parks on the last slot once done
			axi_rd({4'h0, OFS_STATUS}, {25'h0, SLOT_LAST, 1'b0, it == 2, 2'b01}, '1, RESP_OKAY);
			if (it == 2)
			begin
				axi_wr({4'h0, OFS_CTRL}, 32'h2, RESP_OKAY);
				axi_rd({4'h0, OFS_STATUS}, {25'h0, SLOT_LAST, 4'h1}, '1, RESP_OKAY);
			end
		end
		// Refused accesses answer SLVERR; the control word reads back as zero
		axi_wr({4'h0, OFS_STATUS}, 32'h1, RESP_SLVERR);
		axi_wr(12'h006, 32'h1, RESP_SLVERR);
		axi_wr(12'h104, 32'h1, RESP_SLVERR);
		axi_rd(12'h008, 32'h0, '1, RESP_SLVERR);
		axi_rd({4'h0, OFS_CTRL}, 32'h0, '1, RESP_OKAY);
		// A reload with its byte lane masked off is accepted but must not restart
		s_axi_wstrb <= 4'he;
		axi_wr({4'h0, OFS_CTRL}, 32'h1, RESP_OKAY);
		s_axi_wstrb <= 4'hf;
		chk("ready_kept", 1'b1, cfg_ready);
		print_verdict();
	end
endmodule
